//--- verilog/automatic_transfer_mode_support.sv
`include "automatic_transfer_mode_regs.svh"
module automatic_transfer_mode_support
  import automatic_transfer_mode_pkg::*;
#(
  parameter int N_EP = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [N_EP*8-1:0] i_ep_status,
  input wire logic i_is_tx,
  input wire logic i_iso,
  input wire logic i_rx_good_moved,
  input wire logic i_tx_sent_ok,
  input wire logic i_bus_error,
  input wire logic i_short_packet,
  input wire logic i_halt_request,
  output logic o_auto_mode,
  output logic o_tx_reload,
  output logic o_rx_flush,
  output logic o_rx_drop,
  output logic o_summary_flag,
  output logic [3:0] o_events
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [3:0] mask;
    logic [7:0] count;
    logic [7:0] errctl;
    logic [3:0] events;
    logic [3:0] ctl;
    mode_t mode;
    logic [7:0] rdata;
    logic tx_reload;
    logic rx_flush;
    logic rx_drop;
    logic summary;
  } state_t;
  state_t s_q, s_d;
  logic rst_n;
  logic [7:0] mirror;
  logic [6:0] err_count;
  logic err_exhausted;
  logic active;
  logic ok;
  logic bad;
  logic auto_error_handling;

  assign rst_n = s_q.rst_sync[1];
  assign active = (s_q.mode == ST_RUN);
  assign auto_error_handling = s_q.errctl[`ERR_AEH];
  assign ok = active && (i_is_tx ? i_tx_sent_ok : i_rx_good_moved); // [RULE6] [RULE7]
  assign bad = active && i_bus_error;

  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = i_wr && (i_addr == a);
  endfunction

  status_mirror #(.N_EP(N_EP)) u_mirror (
    .i_sel(src_sel_t'(s_q.ctl[2:0])),
    .i_status(i_ep_status),
    .o_mirror(mirror)
  );

  error_counter u_errcnt (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_preset(s_q.errctl[6:0]),
    .i_active(active),
    .i_ok(ok),
    .i_err(bad),
    .o_count(err_count),
    .o_exhausted(err_exhausted)
  );

  always_comb begin
    logic [3:0] ev_set;
    logic [3:0] ev_clr;
    ev_set = 4'h0;
    ev_clr = 4'h0;
    s_d = s_q;
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
    s_d.tx_reload = 1'b0;
    s_d.rx_flush = 1'b0;
    s_d.rx_drop = 1'b0;
    // Successful packet: count down or signal count-done at zero
    if (ok) begin
      if (s_q.count != 8'h00) begin
        s_d.count = s_q.count - 8'h01; // [RULE4]
      end else begin
        ev_set[`EV_COUNT] = 1'b1; // [RULE5]
      end
    end
    if (bad) begin
      if (auto_error_handling) begin
        // Retry actions only while enable bit is set this cycle
        s_d.tx_reload = i_is_tx && !i_iso; // [RULE13] [RULE14] [RULE17]
        s_d.rx_flush = !i_is_tx; // [RULE15] [RULE16] [RULE17]
        s_d.rx_drop = !i_is_tx && i_iso; // [RULE16]
        if (err_exhausted) begin
          ev_set[`EV_ERROR] = 1'b1; // [RULE18]
        end
      end else if (err_exhausted || !auto_error_handling) begin
        ev_set[`EV_ERROR] = 1'b1; // [RULE12]
      end
    end
    if (active && i_short_packet && !i_is_tx) begin
      ev_set[`EV_SHORT] = 1'b1;
    end
    if (active && (i_halt_request || (wr_hit(`ADDR_TRANSFER_CONTROL)
        && !i_wdata[`CTL_AUTO]))) begin
      ev_set[`EV_HALT] = 1'b1;
    end
    if (wr_hit(`ADDR_EVENT_FLAGS)) begin
      ev_clr = i_wdata[3:0];
    end
    // Hardware set wins over a same-cycle clear
    s_d.events = (s_q.events & ~ev_clr) | ev_set;
    if (wr_hit(`ADDR_EVENT_MASK)) begin
      s_d.mask = i_wdata[3:0];
    end
    if (wr_hit(`ADDR_PACKET_COUNT)) begin
      s_d.count = i_wdata; // [RULE9]
    end
    if (wr_hit(`ADDR_ERROR_CONTROL)) begin
      s_d.errctl = i_wdata; // [RULE20]
    end
    if (wr_hit(`ADDR_TRANSFER_CONTROL)) begin
      s_d.ctl = i_wdata[3:0];
    end
    unique case (s_q.mode)
      ST_IDLE: begin
        if (s_d.ctl[`CTL_AUTO] && s_q.events == 4'h0) begin
          s_d.mode = ST_RUN; // [RULE19]
        end else begin
          // A refused start must not linger and fire once events are cleared
          s_d.ctl[`CTL_AUTO] = 1'b0; // [RULE19]
        end
      end
      ST_RUN: begin
        if (!s_d.ctl[`CTL_AUTO] || s_d.events != 4'h0) begin
          s_d.mode = ST_IDLE; // [RULE19]
          s_d.ctl[`CTL_AUTO] = 1'b0;
        end
      end
    endcase
    s_d.summary = |(s_d.events & s_d.mask); // [RULE1] [RULE21]
    s_d.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `ADDR_EVENT_MASK: s_d.rdata = {4'h0, s_q.mask};
        `ADDR_STATUS_MIRROR: s_d.rdata = mirror; // [RULE2] [RULE3]
        `ADDR_PACKET_COUNT: s_d.rdata = s_q.count;
        `ADDR_ERROR_CONTROL: s_d.rdata = s_q.errctl;
        `ADDR_EVENT_FLAGS: s_d.rdata = {4'h0, s_q.events};
        `ADDR_TRANSFER_CONTROL: s_d.rdata = {4'h0, s_q.ctl};
        `ADDR_ALT_EVENT: s_d.rdata = {s_q.summary, 7'h00};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '{rst_sync: 2'b00, mask: `RST_MASK, count: `RST_COUNT,
               errctl: `RST_ERRCTL, events: 4'h0, ctl: 4'h0, mode: ST_IDLE,
               rdata: 8'h00, tx_reload: 1'b0, rx_flush: 1'b0, rx_drop: 1'b0,
               summary: 1'b0};
    end else if (!rst_n) begin
      s_q <= '{rst_sync: s_d.rst_sync, mask: `RST_MASK, count: `RST_COUNT,
               errctl: `RST_ERRCTL, events: 4'h0, ctl: 4'h0, mode: ST_IDLE,
               rdata: 8'h00, tx_reload: 1'b0, rx_flush: 1'b0, rx_drop: 1'b0,
               summary: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  // Run is the only mode code with bit 0 set
  assign o_auto_mode = s_q.mode[0];
  assign o_tx_reload = s_q.tx_reload;
  assign o_rx_flush = s_q.rx_flush;
  assign o_rx_drop = s_q.rx_drop;
  assign o_summary_flag = s_q.summary;
  assign o_events = s_q.events;

  a_count_floor: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE4]
    ok && s_q.count == 8'h00 && !wr_hit(`ADDR_PACKET_COUNT) |=> s_q.count == 8'h00)
    else $error("packet count wrapped");
  a_count_done: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE5]
    ok && s_q.count == 8'h00 |=> s_q.events[`EV_COUNT])
    else $error("count-done not set");
  a_count_write: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE9]
    wr_hit(`ADDR_PACKET_COUNT) |=> s_q.count == $past(i_wdata))
    else $error("count write lost");
  a_summary_gate: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE21]
    o_summary_flag == |(o_events & s_q.mask))
    else $error("summary flag mismatch");
  a_mask_block: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE1]
    s_q.mask == 4'h0 && !wr_hit(`ADDR_EVENT_MASK) |=> !o_summary_flag)
    else $error("masked event raised summary");
  a_mode_stop: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE19]
    active && s_d.events != 4'h0 |=> !active)
    else $error("auto mode not ended");
  a_retry_off: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE17]
    !auto_error_handling |=> !o_tx_reload && !o_rx_flush && !o_rx_drop)
    else $error("retry while handling off");
  a_err_withheld: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE18]
    auto_error_handling && bad && err_count != 7'h00 && !s_q.events[`EV_ERROR] |=> !s_q.events[`EV_ERROR])
    else $error("error event not withheld");
  a_mirror_read: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE3]
    i_rd && i_addr == `ADDR_STATUS_MIRROR |=> o_rdata == $past(mirror))
    else $error("mirror read wrong");
  a_count_decrement: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE4]
    ok && s_q.count != 8'h00 && !wr_hit(`ADDR_PACKET_COUNT)
    |=> s_q.count == $past(s_q.count) - 8'h01)
    else $error("packet count did not decrement");
  a_rx_count_hold: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE6]
    !i_is_tx && !i_rx_good_moved && !wr_hit(`ADDR_PACKET_COUNT) |=> $stable(s_q.count))
    else $error("receive count moved without a good packet");
  a_tx_count_hold: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE7]
    i_is_tx && !i_tx_sent_ok && !wr_hit(`ADDR_PACKET_COUNT) |=> $stable(s_q.count))
    else $error("transmit count moved without a good send");
  a_done_held_off: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE5]
    ok && s_q.count != 8'h00 && !s_q.events[`EV_COUNT] |=> !s_q.events[`EV_COUNT])
    else $error("count-done set early");
  a_error_at_zero: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE12]
    bad && err_count == 7'h00 |=> s_q.events[`EV_ERROR])
    else $error("error event missing at zero count");
  a_tx_reload: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE14]
    bad && auto_error_handling && i_is_tx && !i_iso |=> o_tx_reload)
    else $error("unacked packet not reloaded");
  a_rx_flush: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE15]
    bad && auto_error_handling && !i_is_tx |=> o_rx_flush)
    else $error("bad receive packet not flushed");
  a_iso_drop: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE16]
    bad && auto_error_handling && !i_is_tx && i_iso |=> o_rx_drop)
    else $error("bad iso packet not dropped");
  a_retry_cause: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE13]
    !bad |=> !o_tx_reload && !o_rx_flush && !o_rx_drop)
    else $error("retry without a bus error");
  a_start_refused: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE19]
    !active && s_q.events != 4'h0 |=> !active)
    else $error("auto mode started with event pending");
  a_errctl_write: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE20]
    wr_hit(`ADDR_ERROR_CONTROL) |=> s_q.errctl == $past(i_wdata))
    else $error("error control write lost");
  a_halt_on_stop: assert property (@(posedge i_clk) disable iff (!rst_n) // [RULE19]
    active && wr_hit(`ADDR_TRANSFER_CONTROL) && !i_wdata[`CTL_AUTO] |=> s_q.events[`EV_HALT])
    else $error("stop did not raise halt event");
  c_error_event: cover property (@(posedge i_clk) disable iff (!rst_n) s_q.events[`EV_ERROR]);
  c_count_done: cover property (@(posedge i_clk) disable iff (!rst_n) s_q.events[`EV_COUNT]);
  c_tx_reload: cover property (@(posedge i_clk) disable iff (!rst_n) o_tx_reload);
  c_iso_drop: cover property (@(posedge i_clk) disable iff (!rst_n) o_rx_drop);
  c_run: cover property (@(posedge i_clk) disable iff (!rst_n) active ##1 !active);
endmodule

//--- shared/automatic_transfer_mode_regs.svh
// Summary of operation
// RULE1 - Mask bit enables its event into summary
// RULE2 - Mirror read leaves endpoint status untouched
// RULE3 - Mirror follows selected endpoint, DMA state irrelevant
// RULE4 - Packet count decrements, saturates at zero
// RULE5 - Count-done sets on next success at zero
// RULE6 - Receive decrements after good packet moved
// RULE7 - Transmit decrements after fetch and good send
// RULE8 - Firmware loads packet count minus one
// RULE9 - Count write beats same-cycle decrement
// RULE10 - Seven-bit error counter, preset, decrements per error
// RULE11 - Counter reloads on success and mode stop
// RULE12 - Error at zero count sets error event
// RULE13 - Non-iso handling covers CRC and stuffing errors
// RULE14 - Non-iso transmit unacked packet reloaded, resent
// RULE15 - Non-iso receive bad packet flushed for retry
// RULE16 - Iso receive bad packet flushed, not moved
// RULE17 - Clearing handling enable stops all retries immediately
// RULE18 - With handling on, error event withheld until exhausted
// RULE19 - Any event ends automatic mode, blocks start
// RULE20 - Error control: preset low seven, enable bit seven
// RULE21 - Summary flag is OR of masked events
`ifndef AUTOMATIC_TRANSFER_MODE_REGS_SVH
`define AUTOMATIC_TRANSFER_MODE_REGS_SVH
`define ADDR_EVENT_MASK 4'h0
`define ADDR_STATUS_MIRROR 4'h1
`define ADDR_PACKET_COUNT 4'h2
`define ADDR_ERROR_CONTROL 4'h3
`define ADDR_EVENT_FLAGS 4'h4
`define ADDR_TRANSFER_CONTROL 4'h5
`define ADDR_ALT_EVENT 4'h6
`define EV_HALT 0
`define EV_ERROR 1
`define EV_COUNT 2
`define EV_SHORT 3
`define CTL_AUTO 3
`define CTL_SRC_LSB 0
`define ERR_AEH 7
`define RST_MASK 4'h0
`define RST_COUNT 8'h00
`define RST_ERRCTL 8'h00
`define ALT_DMA_BIT 7
`endif

//--- shared/automatic_transfer_mode_pkg.sv
package automatic_transfer_mode_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } mode_t;
  typedef logic [2:0] src_sel_t;
endpackage

//--- verilog/status_mirror.sv
`include "automatic_transfer_mode_regs.svh"
module status_mirror
  import automatic_transfer_mode_pkg::*;
#(
  parameter int N_EP = 8
) (
  input wire logic [2:0] i_sel,
  input wire logic [N_EP*8-1:0] i_status,
  output logic [7:0] o_mirror
);
  // Combinational view only; no read strobe reaches the status sources
  always_comb begin
    o_mirror = i_status[i_sel*8 +: 8]; // [RULE2] [RULE3]
  end
endmodule

//--- verilog/error_counter.sv
`include "automatic_transfer_mode_regs.svh"
module error_counter
  import automatic_transfer_mode_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [6:0] i_preset,
  input wire logic i_active,
  input wire logic i_ok,
  input wire logic i_err,
  output logic [6:0] o_count,
  output logic o_exhausted
);
  typedef struct packed {
    logic [6:0] cnt;
  } ec_state_t;
  ec_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (!i_active || i_ok) begin
      s_d.cnt = i_preset; // [RULE11]
    end else if (i_err && s_q.cnt != 7'h00) begin
      s_d.cnt = s_q.cnt - 7'h01; // [RULE10]
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_count = s_q.cnt;
  assign o_exhausted = i_active && i_err && (s_q.cnt == 7'h00); // [RULE12]
  a_err_decrement: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE10]
    i_active && !i_ok && i_err && s_q.cnt != 7'h00 |=> s_q.cnt == $past(s_q.cnt) - 7'h01)
    else $error("error counter did not decrement");
  a_err_reload: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE11]
    (!i_active || i_ok) |=> s_q.cnt == $past(i_preset))
    else $error("error counter did not reload");
endmodule

//--- tb/dma_partner.sv
module dma_partner (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [2:0] i_kind,
  input wire logic [1:0] i_wait,
  output logic o_busy,
  output logic [4:0] o_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q;
  logic [2:0] kind_q;
  initial begin
    o_busy = 1'b0;
    o_pulse = 5'h00;
  end
  // One outcome pulse per request; a stall shows slow memory or bus
  always @(posedge i_clk) begin
    o_pulse <= 5'h00;
    if (i_req && !o_busy) begin
      o_busy <= 1'b1;
      wait_q <= i_wait;
      kind_q <= i_kind;
    end else if (o_busy && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (o_busy) begin
      o_pulse <= 5'h01 << kind_q;
      o_busy <= 1'b0;
    end
  end
endmodule

//--- tb/testbench.sv
`include "automatic_transfer_mode_regs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module testbench import automatic_transfer_mode_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_resetn, i_wr, i_rd, i_is_tx, i_iso, req, busy, o_auto_mode;
  logic o_tx_reload, o_rx_flush, o_rx_drop, o_summary_flag;
  logic [3:0] i_addr, o_events;
  logic [7:0] i_wdata, o_rdata, v;
  logic [63:0] i_ep_status;
  logic [4:0] pulse;
  logic [2:0] kind;
  logic [1:0] wt;
  logic [3:0] reset_addrs [4] = '{4'h0, 4'h2, 4'h3, 4'hF};
  int failures, check_count;
  dma_partner far (.i_clk, .i_req(req), .i_kind(kind), .i_wait(wt), .o_busy(busy),
    .o_pulse(pulse));
  automatic_transfer_mode_support dut (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_ep_status, .i_is_tx, .i_iso, .i_rx_good_moved(pulse[0]), .i_tx_sent_ok(pulse[1]),
    .i_bus_error(pulse[2]), .i_short_packet(pulse[3]), .i_halt_request(pulse[4]),
    .o_auto_mode, .o_tx_reload, .o_rx_flush, .o_rx_drop, .o_summary_flag, .o_events);
  function automatic logic [7:0] mirror_exp(logic [63:0] s, int k);
    return s[k*8 +: 8];
  endfunction
  function automatic logic [2:0] retry_exp(logic tx, logic iso);
    if (tx) return iso ? 3'b000 : 3'b100;
    return iso ? 3'b011 : 3'b010;
  endfunction
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // With a zero wait, the cw write lands on the same edge as the pulse and its decrement
  task automatic outcome(logic [2:0] k, logic [1:0] w, bit cw = 0);
    int n;
    @(posedge i_clk);
    req <= 1'b1;
    kind <= k;
    wt <= w;
    @(posedge i_clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      i_wr <= cw && n == 0;
      n++;
    end while (busy && n < 8);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  initial begin
    repeat (8000) @(posedge i_clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    {i_resetn, i_wr, i_rd, i_is_tx, i_iso, req} = 6'h00;
    {i_addr, i_wdata, kind, wt, i_ep_status} = '0;
    v = 8'($urandom(77));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    foreach (reset_addrs[a]) begin
      rd(reset_addrs[a], v);
      `CHK("reset value", 8'h00, v)
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk);
      i_ep_status <= {$urandom, $urandom};
      wr(`ADDR_TRANSFER_CONTROL, 8'(k));
      repeat (2) begin
        rd(`ADDR_STATUS_MIRROR, v);
        `CHK("mirror", mirror_exp(i_ep_status, k), v)
      end
    end
    // Three packets, so the count is loaded with two
    wr(`ADDR_PACKET_COUNT, 8'h02);
    wr(`ADDR_TRANSFER_CONTROL, 8'h08);
    i_is_tx <= 1'b1;
    outcome(3'd0, 2'd0);
    rd(`ADDR_PACKET_COUNT, v);
    `CHK("count", 8'h02, v)
    i_is_tx <= 1'b0;
    outcome(3'd0, 2'($urandom));
    rd(`ADDR_PACKET_COUNT, v);
    `CHK("count", 8'h01, v)
    i_is_tx <= 1'b1;
    outcome(3'd1, 2'($urandom));
    `CHK("events", 4'h0, o_events)
    outcome(3'd1, 2'($urandom));
    rd(`ADDR_PACKET_COUNT, v);
    `CHK("count", 8'h00, v)
    `CHK("events", 4'h4, o_events)
    wr(`ADDR_TRANSFER_CONTROL, 8'h08);
    #1 `CHK("auto mode", 1'b0, o_auto_mode)
    for (int b = 0; b < 16; b++) begin
      rd(`ADDR_EVENT_MASK, v);
      `CHK("mask", 8'(b == 0 ? 0 : b - 1), v)
      wr(`ADDR_EVENT_MASK, 8'(b));
      @(posedge i_clk);
      #1 `CHK("summary", |(4'(b) & 4'h4), o_summary_flag)
      rd(`ADDR_ALT_EVENT, v);
      `CHK("alt event", {|(4'(b) & 4'h4), 7'h00}, v)
    end
    wr(`ADDR_PACKET_COUNT, 8'h05);
    wr(`ADDR_EVENT_FLAGS, 8'h0F);
    // The refused start above must not come back once events clear
    @(posedge i_clk);
    #1 `CHK("auto mode", 1'b0, o_auto_mode)
    wr(`ADDR_TRANSFER_CONTROL, 8'h08);
    i_addr <= `ADDR_PACKET_COUNT;
    i_wdata <= 8'h09;
    outcome(3'd1, 2'd0, 1'b1);
    rd(`ADDR_PACKET_COUNT, v);
    `CHK("count", 8'h09, v)
    for (int m = 0; m < 3; m++) begin
      i_is_tx <= m == 0;
      i_iso <= m == 2;
      // Stop first so the counter takes the new preset while idle
      wr(`ADDR_TRANSFER_CONTROL, 8'h00);
      wr(`ADDR_EVENT_FLAGS, 8'h0F);
      wr(`ADDR_ERROR_CONTROL, 8'h81);
      wr(`ADDR_TRANSFER_CONTROL, 8'h08);
      rd(`ADDR_STATUS_MIRROR, v);
      `CHK("mirror", mirror_exp(i_ep_status, 0), v)
      outcome(3'd2, 2'($urandom));
      `CHK("retry", retry_exp(i_is_tx, i_iso), {o_tx_reload, o_rx_flush, o_rx_drop})
      outcome(m == 0 ? 3'd1 : 3'd0, 2'($urandom));
      outcome(3'd2, 2'($urandom));
      `CHK("events", 4'h0, o_events)
      outcome(3'd2, 2'($urandom));
      `CHK("events", 4'h2, o_events)
    end
    wr(`ADDR_EVENT_FLAGS, 8'h0F);
    wr(`ADDR_ERROR_CONTROL, 8'h03);
    wr(`ADDR_TRANSFER_CONTROL, 8'h08);
    outcome(3'd2, 2'd1);
    `CHK("retry", 3'b000, {o_tx_reload, o_rx_flush, o_rx_drop})
    `CHK("events", 4'h2, o_events)
    for (int h = 3; h < 5; h++) begin
      wr(`ADDR_EVENT_FLAGS, 8'h0F);
      wr(`ADDR_TRANSFER_CONTROL, 8'h08);
      outcome(3'(h), 2'($urandom));
      `CHK("events", h == 3 ? 4'h8 : 4'h1, o_events)
      `CHK("auto mode", 1'b0, o_auto_mode)
    end
    tally_and_finish();
  end
endmodule
